/* dio_bus_pkg.sv */
// Package with the command layout, register map and reset values of the script executor.
package dio_bus_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] ADDR_CMD = 8'h00;
  localparam logic [7:0] ADDR_STAT = 8'h04;
  localparam logic [7:0] ADDR_HS = 8'h08;
  localparam logic [7:0] ADDR_DIN = 8'h0c;

  // Field positions inside the status word.
  localparam int STAT_OUT_LSB = 0;
  localparam int STAT_DIR_LSB = 8;
  localparam int STAT_PULLUP_BIT = 16;
  localparam int STAT_HS_BIT = 17;
  localparam int STAT_ERR_BIT = 18;

  // Field positions inside the high speed word.
  localparam int HS_MCODE_LSB = 0;
  localparam int HS_RATE_LSB = 8;

  // Fixed upper pattern of the high speed master code.
  localparam logic [4:0] MCODE_PREFIX = 5'h01;

  // Reset values.
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_DIR = 8'h00;
  localparam logic RST_PULLUP = 1'b0;
  localparam logic RST_HS = 1'b0;
  localparam logic [7:0] RST_MCODE = {MCODE_PREFIX, 3'h0};
  localparam logic [7:0] RST_RATE = 8'h00;

  // The only port index that a single-port adapter accepts.
  localparam logic PORT_ONLY = 1'b0;

  typedef enum logic [3:0] {
    OP_NOP = 4'h0,
    OP_WR_LINE = 4'h1,
    OP_WR_PORT = 4'h2,
    OP_PULLUP = 4'h3,
    OP_HS_EN = 4'h4,
    OP_DIR = 4'h5,
    OP_HS_MCODE = 4'h6,
    OP_HS_RATE = 4'h7
  } op_e;

  // Command word as written to the command register: {op, port, line, arg}.
  typedef struct packed {
    logic [15:0] unused;
    op_e op;
    logic port;
    logic [2:0] line;
    logic [7:0] arg;
  } cmd_s;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } bus_req_s;

endpackage

/* dio_in_sync.sv */
// Two-stage synchroniser for the eight digital I/O input pins.
`timescale 1ns/1ps
`default_nettype none
module dio_in_sync (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_pins,
  output logic [7:0] o_sync
);

  logic [7:0] meta_q;
  logic [7:0] sync_q;

  // The first stage feeds only the second stage, so metastability cannot spread.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      meta_q <= 8'h00;
      sync_q <= 8'h00;
    end else begin
      meta_q <= i_pins;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule
`default_nettype wire

/* dio_bus_setup.sv */
// Script command executor: digital I/O writes, pull-up control and high speed mode.
`timescale 1ns/1ps
`default_nettype none
module dio_bus_setup (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic i_re,
  output logic [31:0] o_rdata,
  input wire logic [7:0] i_dio_in,
  output logic [7:0] o_dio_out,
  output logic [7:0] o_dio_oe_n,
  output logic o_sda_pullup_en,
  output logic o_scl_pullup_en,
  output logic o_hs_en,
  output logic [7:0] o_hs_mcode,
  output logic [7:0] o_hs_rate
);

  typedef struct packed {
    logic pend;
    dio_bus_pkg::cmd_s cmd;
    logic [7:0] out;
    logic [7:0] oe_n;
    logic pullup_sda;
    logic pullup_scl;
    logic hs;
    logic [7:0] mcode;
    logic [7:0] rate;
    logic err;
    logic [31:0] rdata;
  } state_s;

  state_s st_q;
  state_s st_d;
  dio_bus_pkg::bus_req_s req;
  dio_bus_pkg::cmd_s cur;
  logic [7:0] din;
  logic [7:0] dir;
  logic [7:0] line_mask;
  logic cmd_bad;

  // Input pins come from outside the clock domain, so they are synchronised first.
  dio_in_sync u_sync (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pins(i_dio_in),
    .o_sync(din)
  );

  // Gather the register port into one request.
  assign req = '{addr: i_addr, wdata: i_wdata, we: i_we, re: i_re};
  assign cur = st_q.cmd;
  assign dir = ~st_q.oe_n;
  assign line_mask = 8'h01 << cur.line;
  // Nonzero port on a single-port adapter, or high speed values with mode off, are refused.
  assign cmd_bad = (cur.port != dio_bus_pkg::PORT_ONLY) ||
    ((cur.op == dio_bus_pkg::OP_HS_MCODE || cur.op == dio_bus_pkg::OP_HS_RATE) && !st_q.hs);

  // Read mux; unmapped offsets answer zero.
  function automatic logic [31:0] read_word(input logic [7:0] addr, input state_s s,
                                            input logic [7:0] pins);
    logic [31:0] w;
    w = 32'h0000_0000;
    case (addr)
      dio_bus_pkg::ADDR_CMD: w = s.cmd;
      dio_bus_pkg::ADDR_STAT: begin
        w[dio_bus_pkg::STAT_OUT_LSB +: 8] = s.out;
        w[dio_bus_pkg::STAT_DIR_LSB +: 8] = ~s.oe_n;
        w[dio_bus_pkg::STAT_PULLUP_BIT] = s.pullup_sda;
        w[dio_bus_pkg::STAT_HS_BIT] = s.hs;
        w[dio_bus_pkg::STAT_ERR_BIT] = s.err;
      end
      dio_bus_pkg::ADDR_HS: begin
        w[dio_bus_pkg::HS_MCODE_LSB +: 8] = s.mcode;
        w[dio_bus_pkg::HS_RATE_LSB +: 8] = s.rate;
      end
      dio_bus_pkg::ADDR_DIN: w[7:0] = pins;
      default: w = 32'h0000_0000;
    endcase
    return w;
  endfunction

  // Next state: capture a written command, execute the one captured last cycle.
  // Capture and execution overlap, so back-to-back commands still run strictly in order.
  always_comb begin
    st_d = st_q;
    st_d.pend = 1'b0;
    st_d.rdata = req.re ? read_word(req.addr, st_q, din) : 32'h0000_0000;
    if (st_q.pend) begin
      if (cmd_bad) begin
        st_d.err = 1'b1;
      end else begin
        case (cur.op)
          dio_bus_pkg::OP_WR_LINE: begin
            // Only the addressed bit is touched; any nonzero value counts as high.
            if (cur.arg != 8'h00) begin
              st_d.out = st_q.out | line_mask;
            end else begin
              st_d.out = st_q.out & ~line_mask;
            end
          end
          dio_bus_pkg::OP_WR_PORT: begin
            st_d.out = (st_q.out & ~dir) | (cur.arg & dir);
          end
          dio_bus_pkg::OP_DIR: begin
            st_d.oe_n = ~cur.arg;
          end
          dio_bus_pkg::OP_PULLUP: begin
            st_d.pullup_sda = cur.arg[0];
            st_d.pullup_scl = cur.arg[0];
          end
          dio_bus_pkg::OP_HS_EN: begin
            st_d.hs = cur.arg[0];
          end
          dio_bus_pkg::OP_HS_MCODE: begin
            st_d.mcode = {dio_bus_pkg::MCODE_PREFIX, cur.arg[2:0]};
          end
          dio_bus_pkg::OP_HS_RATE: begin
            st_d.rate = cur.arg;
          end
          default: begin
            st_d.err = st_q.err;
          end
        endcase
      end
    end
    if (req.we && req.addr == dio_bus_pkg::ADDR_CMD) begin
      st_d.cmd = dio_bus_pkg::cmd_s'(req.wdata);
      st_d.pend = 1'b1;
    end
    // Writing 1 clears the error flag, but a refusal in the same cycle wins.
    if (req.we && req.addr == dio_bus_pkg::ADDR_STAT && req.wdata[dio_bus_pkg::STAT_ERR_BIT]
        && !(st_q.pend && cmd_bad)) begin
      st_d.err = 1'b0;
    end
  end

  // All state registers in one place.
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      st_q <= '{pend: 1'b0, cmd: '0, out: dio_bus_pkg::RST_OUT,
                oe_n: ~dio_bus_pkg::RST_DIR, pullup_sda: dio_bus_pkg::RST_PULLUP,
                pullup_scl: dio_bus_pkg::RST_PULLUP, hs: dio_bus_pkg::RST_HS,
                mcode: dio_bus_pkg::RST_MCODE, rate: dio_bus_pkg::RST_RATE,
                err: 1'b0, rdata: 32'h0000_0000};
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state flops.
  assign o_rdata = st_q.rdata;
  assign o_dio_out = st_q.out;
  assign o_dio_oe_n = st_q.oe_n;
  assign o_sda_pullup_en = st_q.pullup_sda;
  assign o_scl_pullup_en = st_q.pullup_scl;
  assign o_hs_en = st_q.hs;
  assign o_hs_mcode = st_q.mcode;
  assign o_hs_rate = st_q.rate;

endmodule
`default_nettype wire

/* dio_bus_setup_properties.sv */
// Concurrent checks of the script executor's outputs against the commands written to it.
`timescale 1ns/1ps
`default_nettype none
module dio_bus_setup_properties (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_we,
  input wire logic [7:0] o_dio_out,
  input wire logic [7:0] o_dio_oe_n,
  input wire logic o_sda_pullup_en,
  input wire logic o_scl_pullup_en,
  input wire logic o_hs_en,
  input wire logic [7:0] o_hs_mcode,
  input wire logic [7:0] o_hs_rate
);
  default clocking @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // A command write is taken, executed one edge later, and seen after the next edge.
  sequence s_cmd(logic [3:0] op);
    i_we && i_addr == dio_bus_pkg::ADDR_CMD && i_wdata[15:12] == op && !i_wdata[11];
  endsequence
  property p_line;
    s_cmd(4'h1) |-> ##2 o_dio_out[$past(i_wdata[10:8], 2)] == (|$past(i_wdata[7:0], 2));
  endproperty
  a_line: assert property (p_line) else $error("line level wrong");
  property p_others;
    s_cmd(4'h1) |-> ##2 ((o_dio_out ^ $past(o_dio_out)) & ~(8'h01 << $past(i_wdata[10:8], 2))) == 8'h00;
  endproperty
  a_others: assert property (p_others) else $error("other line moved");
  property p_port;
    s_cmd(4'h2) |-> ##2 ((o_dio_out ^ $past(i_wdata[7:0], 2)) & ~o_dio_oe_n) == 8'h00;
  endproperty
  a_port: assert property (p_port) else $error("port value lost");
  property p_inputs;
    s_cmd(4'h2) |-> ##2 ((o_dio_out ^ $past(o_dio_out)) & o_dio_oe_n) == 8'h00;
  endproperty
  a_inputs: assert property (p_inputs) else $error("input line written");
  property p_pull;
    s_cmd(4'h3) |-> ##2 o_sda_pullup_en == $past(i_wdata[0], 2) && o_scl_pullup_en == o_sda_pullup_en;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up wrong");
  property p_hs;
    s_cmd(4'h4) |-> ##2 o_hs_en == $past(i_wdata[0], 2);
  endproperty
  a_hs: assert property (p_hs) else $error("high speed flag wrong");
  property p_gate;
    $changed(o_hs_mcode) |-> $past(o_hs_en);
  endproperty
  a_gate: assert property (p_gate) else $error("code changed while off");
  property p_rate_gate;
    $changed(o_hs_rate) |-> $past(o_hs_en);
  endproperty
  a_rate_gate: assert property (p_rate_gate) else $error("rate changed while off");
  property p_dir;
    s_cmd(4'h5) |-> ##2 o_dio_oe_n == ~$past(i_wdata[7:0], 2);
  endproperty
  a_dir: assert property (p_dir) else $error("direction wrong");
  property p_code;
    s_cmd(4'h6) ##1 o_hs_en |=> o_hs_mcode == {dio_bus_pkg::MCODE_PREFIX, $past(i_wdata[2:0], 2)};
  endproperty
  a_code: assert property (p_code) else $error("master code wrong");
endmodule
bind dio_bus_setup dio_bus_setup_properties chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_we(i_we), .o_dio_out(o_dio_out),
  .o_dio_oe_n(o_dio_oe_n), .o_sda_pullup_en(o_sda_pullup_en),
  .o_scl_pullup_en(o_scl_pullup_en), .o_hs_en(o_hs_en), .o_hs_mcode(o_hs_mcode),
  .o_hs_rate(o_hs_rate));
`default_nettype wire

/* dio_far_side.sv */
// Pin model of the circuit wired to the digital I/O port.
`timescale 1ns/1ps
`default_nettype none
module dio_far_side #(parameter logic [7:0] EXT = 8'ha5) (
  input wire logic [7:0] i_out,
  input wire logic [7:0] i_oe_n,
  output logic [7:0] o_pins
);
  // Released lines show the outside source, so a stale drive can never pass for input.
  assign o_pins = (~i_oe_n & i_out) | (i_oe_n & EXT);
endmodule
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the script executor.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; $display("BAD %0t %h %h", $time, a, e); end end
module tb_top;
  logic i_sys_clk = 1'b0, i_rst = 1'b1, i_we = 1'b0, i_re = 1'b0, sda, scl, hs;
  logic [7:0] i_addr = 8'h00, pins, dout, oe_n, mcode, rate;
  logic [31:0] i_wdata = 32'h0, rdata;
  int error_cnt = 0, n_tests = 0, cyc = 0;
  dio_bus_setup dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_we(i_we), .i_re(i_re), .o_rdata(rdata), .i_dio_in(pins), .o_dio_out(dout),
    .o_dio_oe_n(oe_n), .o_sda_pullup_en(sda), .o_scl_pullup_en(scl), .o_hs_en(hs),
    .o_hs_mcode(mcode), .o_hs_rate(rate));
  dio_far_side far (.i_out(dout), .i_oe_n(oe_n), .o_pins(pins));
  initial forever #20 i_sys_clk = ~i_sys_clk;
  // The whole run needs well under a hundred cycles; a hang is cut here.
  always @(posedge i_sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // The write strobe is left high so back-to-back writes never assign it twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_addr <= a;
    i_wdata <= d;
    i_we <= 1'b1;
    i_re <= 1'b0;
    @(posedge i_sys_clk);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [2:0] ln, input logic [7:0] arg);
    wr(dio_bus_pkg::ADDR_CMD, {16'h0000, op, 1'b0, ln, arg});
  endtask
  // Drop the strobe, let the last command land, then look in mid-cycle when all is settled.
  task automatic settle();
    i_we <= 1'b0;
    i_re <= 1'b0;
    repeat (2) @(posedge i_sys_clk);
    @(negedge i_sys_clk);
  endtask
  // Read data stand only in the cycle after the strobe, so they are checked in that cycle.
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    i_addr <= a;
    i_re <= 1'b1;
    i_we <= 1'b0;
    @(posedge i_sys_clk);
    i_re <= 1'b0;
    @(negedge i_sys_clk);
    `CHK(rdata, e)
    @(posedge i_sys_clk);
  endtask
  task automatic t_reset();
    `CHK(oe_n, 8'hff)
    rd(dio_bus_pkg::ADDR_STAT, 32'h0);
    rd(dio_bus_pkg::ADDR_HS, 32'h00000008);
    rd(8'h10, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_lines();
    cmd(4'h5, 3'h0, 8'hff);
    cmd(4'h1, 3'h0, 8'h01);
    cmd(4'h1, 3'h7, 8'h01);
    cmd(4'h1, 3'h7, 8'h00);
    cmd(4'h1, 3'h7, 8'h01);
    settle();
    `CHK(dout, 8'h81)
    @(posedge i_sys_clk);
    $display("line writes done");
  endtask
  task automatic t_port();
    cmd(4'h5, 3'h0, 8'h0f);
    cmd(4'h2, 3'h0, 8'h3c);
    settle();
    settle();
    `CHK(dout, 8'h8c)
    `CHK(oe_n, 8'hf0)
    @(posedge i_sys_clk);
    rd(dio_bus_pkg::ADDR_DIN, 32'h000000ac);
    // A nonzero port index must be refused and flagged.
    wr(dio_bus_pkg::ADDR_CMD, 32'h00001a00);
    settle();
    `CHK(dout, 8'h8c)
    @(posedge i_sys_clk);
    rd(dio_bus_pkg::ADDR_CMD, 32'h00001a00);
    rd(dio_bus_pkg::ADDR_STAT, 32'h00040f8c);
    wr(dio_bus_pkg::ADDR_STAT, 32'h00040000);
    rd(dio_bus_pkg::ADDR_STAT, 32'h00000f8c);
    $display("port write done");
  endtask
  task automatic t_bus();
    cmd(4'h3, 3'h0, 8'h01);
    cmd(4'h6, 3'h0, 8'h05);
    settle();
    `CHK({sda, scl}, 2'b11)
    `CHK(mcode, 8'h08)
    @(posedge i_sys_clk);
    rd(dio_bus_pkg::ADDR_STAT, 32'h00050f8c);
    cmd(4'h4, 3'h0, 8'h01);
    cmd(4'h6, 3'h0, 8'h05);
    cmd(4'h7, 3'h0, 8'h33);
    cmd(4'h4, 3'h0, 8'h00);
    settle();
    `CHK(mcode, 8'h0d)
    `CHK(rate, 8'h33)
    `CHK(hs, 1'b0)
    @(posedge i_sys_clk);
    // With the mode off a new rate must be refused.
    cmd(4'h7, 3'h0, 8'h44);
    settle();
    `CHK(rate, 8'h33)
    @(posedge i_sys_clk);
    $display("bus setup done");
  endtask
  initial begin
    repeat (2) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    t_reset();
    t_lines();
    t_port();
    t_bus();
    complete_run();
  end
endmodule
`default_nettype wire
